// >>> hw/dsf_pkg.sv
// Purpose: shared constants for the disk status and fault logic
// Assumes: 10 MHz pclk, 32-bit APB, word-aligned registers
// Notes:   times kept in their own unit, cycles derived here
package dsf_pkg;
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned REV_PERIOD_US = 16_670;
  localparam int unsigned REV_CYC       = REV_PERIOD_US * (CLK_HZ / 1_000_000);
  localparam int unsigned READY_MAX_S   = 20;
  localparam int unsigned READY_MAX_CYC = READY_MAX_S * CLK_HZ;
  localparam int unsigned STEP_CLR_NS   = 100;
  localparam int unsigned STEP_CLR_CYC  = (STEP_CLR_NS * (CLK_HZ / 1_000_000))
                                          / 1000;
  localparam int unsigned CYL_W    = 10;
  localparam int unsigned CYL_MAX  = 733;
  localparam int unsigned CYL_RWC1 = 183;
  localparam int unsigned CYL_RWC2 = 266;
  localparam int unsigned CYL_RWC3 = 549;
  localparam int unsigned CYL_PARK = 740;
  // Register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  // Control fields
  localparam int unsigned CTRL_UNIT   = 0;
  localparam int unsigned CTRL_VALID  = 2;
  localparam int unsigned CTRL_RADIAL = 3;
  localparam int unsigned CTRL_DCU    = 4;
  localparam int unsigned CTRL_INIT   = 5;
  localparam int unsigned CTRL_RECAL  = 6;
  localparam logic [6:0]  CTRL_RST    = 7'h00;
  // Status fields
  localparam int unsigned STAT_CYL    = 0;
  localparam int unsigned STAT_READY  = 10;
  localparam int unsigned STAT_SETTLE = 11;
  localparam int unsigned STAT_HAZ    = 12;
  localparam int unsigned STAT_SEL    = 13;
  localparam int unsigned STAT_LVL    = 14;
  localparam int unsigned STAT_LATE   = 16;
  localparam int unsigned STAT_RETRY  = 17;
  typedef enum logic [2:0] {
    DSF_SPIN, DSF_RECAL, DSF_INIT, DSF_RDY, DSF_RUN, DSF_SEEK
  } dsf_seq_e;
endpackage : dsf_pkg

// >>> hw/dsf_rev_gen.sv
// Purpose: once-per-revolution marker pulse
// Assumes: enable rises once heads leave the parking zone
// Notes:   period and width are cycles of pclk
`timescale 1ns/1ps
module dsf_rev_gen #(
  parameter int unsigned PERIOD = dsf_pkg::REV_CYC,
  parameter int unsigned WIDTH  = 16
) (
  // Clock, reset and enable
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  // Sequencer side
  dsf_rev_if.gen    rev
);
  logic [31:0] cnt_r;
  logic        mark_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 32'h0;
    end else if (ce) begin
      if (!rev.enable || cnt_r == PERIOD - 1) begin
        cnt_r <= 32'h0;
      end else begin
        cnt_r <= cnt_r + 32'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mark_r <= 1'b1;
    end else if (ce) begin
      mark_r <= !(rev.enable && cnt_r < WIDTH);
    end
  end

  assign rev.marker_n = mark_r || !rev.enable;

  property p_rev_width;
    @(posedge pclk) disable iff (!presetn)
    !mark_r |-> $past(cnt_r) < WIDTH;
  endproperty
  a_rev_width: assert property (p_rev_width)
    else $error("marker pulse too wide");

  property p_rev_park;
    @(posedge pclk) disable iff (!presetn)
    !rev.enable |-> rev.marker_n;
  endproperty
  a_rev_park: assert property (p_rev_park)
    else $error("marker active while parked");
endmodule : dsf_rev_gen

// >>> hw/dsf_rev_if.sv
// Purpose: link between sequencer and revolution marker generator
// Assumes: single pclk domain
// Notes:   marker_n is active low
`timescale 1ns/1ps
interface dsf_rev_if;
  logic enable;
  logic marker_n;
  modport gen (input enable, output marker_n);
  modport ctl (output enable, input marker_n);
endinterface : dsf_rev_if

// >>> hw/dsf_status.sv
// Purpose: status outputs, power-on sequence and write protection
// Assumes: host pins synchronous to pclk, sensors from drive internals
// Notes:   hazard clears only with presetn, the power-cycle reset
`timescale 1ns/1ps
module dsf_status #(
  parameter int unsigned REV_CYC    = dsf_pkg::REV_CYC,
  parameter int unsigned REV_WIDTH  = 16,
  parameter int unsigned READY_CYC  = dsf_pkg::READY_MAX_CYC,
  parameter int unsigned SETTLE_CYC = 64,
  parameter int unsigned RECAL_DIV  = 8
) (
  // Clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Host control inputs
  input  wire logic [3:0]  unit_sel_n,
  input  wire logic        write_gate_n,
  input  wire logic        step_n,
  input  wire logic        dir_in_n,
  input  wire logic        encoded_write_pair_pos,
  input  wire logic        encoded_write_pair_neg,
  // Drive internal sensors
  input  wire logic        spindle_ok,
  input  wire logic        supply_unsafe,
  input  wire logic        head_sel_fault,
  input  wire logic        off_track,
  input  wire logic        wcur_sense,
  // Host status outputs
  output logic             unit_selected_n,
  output logic             rev_marker_n,
  output logic             home_cyl_n,
  output logic             ready_n,
  output logic             seek_settled_n,
  output logic             write_hazard_n,
  // Write channel controls
  output logic             head_energize,
  output logic             write_current_en,
  output logic             write_flux,
  output logic [1:0]       wr_cur_level
);
  localparam int unsigned CW = dsf_pkg::CYL_W;

  dsf_pkg::dsf_seq_e st_r;
  logic [6:0]    ctrl_r;
  logic [CW-1:0] cyl_r;
  logic [31:0]   settle_r;
  logic [7:0]    div_r;
  logic [1:0]    retry_r;
  logic [31:0]   rdy_cnt_r;
  logic          late_r;
  logic          unparked_r;
  logic          hazard_r;
  logic          step_d_r;
  logic          pair_d_r;
  logic          head_r;
  logic          wcur_r;
  logic          flux_r;
  logic [1:0]    lvl_r;
  logic [31:0]   prdata_r;

  logic          sel;
  logic          wg;
  logic          step_edge;
  logic          step_ok;
  logic          ready_w;
  logic          settled_w;
  logic          retry_ev;
  logic          settle_done;
  logic          recal_req;
  logic          wr_ctrl;
  logic          addr_hit;
  logic          cur_ok;
  logic          pair_w;
  logic [31:0]   stat_w;

  dsf_rev_if rev_link ();

  dsf_rev_gen #(
    .PERIOD (REV_CYC),
    .WIDTH  (REV_WIDTH)
  ) u_rev (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .rev     (rev_link.gen)
  );

  assign sel = ctrl_r[dsf_pkg::CTRL_VALID]
             && (ctrl_r[dsf_pkg::CTRL_RADIAL]
             || !unit_sel_n[ctrl_r[dsf_pkg::CTRL_UNIT +: 2]]);
  assign wg        = sel && !write_gate_n;
  assign step_edge = step_d_r && !step_n;
  // steps only when ready and settled
  assign step_ok   = step_edge && settled_w && !wg;
  assign ready_w   = (st_r == dsf_pkg::DSF_RDY
                   || st_r == dsf_pkg::DSF_RUN
                   || st_r == dsf_pkg::DSF_SEEK) && !supply_unsafe;
  // settled only in run with good supply
  assign settled_w = st_r == dsf_pkg::DSF_RUN && ready_w;
  assign settle_done = st_r == dsf_pkg::DSF_SEEK && settle_r == 32'h0;
  assign retry_ev  = off_track && ready_w && !step_ok
                   && (st_r == dsf_pkg::DSF_RUN || settle_done);
  assign wr_ctrl   = psel && penable && pwrite && ce
                   && paddr == dsf_pkg::ADDR_CTRL;
  assign recal_req = wr_ctrl && pwdata[dsf_pkg::CTRL_RECAL];
  assign addr_hit  = paddr == dsf_pkg::ADDR_CTRL
                   || paddr == dsf_pkg::ADDR_STAT;
  assign pair_w    = encoded_write_pair_pos && !encoded_write_pair_neg;

  // APB: zero-wait, frozen with ce
  assign pready  = ce;
  assign pslverr = psel && penable && !addr_hit;
  assign prdata  = prdata_r;

  always_comb begin
    stat_w = 32'h0;
    stat_w[dsf_pkg::STAT_CYL +: CW]  = cyl_r;
    stat_w[dsf_pkg::STAT_READY]      = ready_w;
    stat_w[dsf_pkg::STAT_SETTLE]     = settled_w;
    stat_w[dsf_pkg::STAT_HAZ]        = hazard_r;
    stat_w[dsf_pkg::STAT_SEL]        = sel;
    stat_w[dsf_pkg::STAT_LVL +: 2]   = lvl_r;
    stat_w[dsf_pkg::STAT_LATE]       = late_r;
    stat_w[dsf_pkg::STAT_RETRY +: 2] = retry_r;
  end

  // Read data captured in setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0;
    end else if (ce && psel && !penable) begin
      if (paddr == dsf_pkg::ADDR_CTRL) begin
        prdata_r <= {25'h0, 1'b0, ctrl_r[5:0]};
      end else if (paddr == dsf_pkg::ADDR_STAT) begin
        prdata_r <= stat_w;
      end else begin
        prdata_r <= 32'h0;
      end
    end
  end

  // Control register; recal bit self-clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= dsf_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= {1'b0, pwdata[5:0]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= dsf_pkg::DSF_SPIN;
    end else if (ce) begin
      if (recal_req && st_r != dsf_pkg::DSF_SPIN) begin
        st_r <= dsf_pkg::DSF_RECAL;
      end else if (supply_unsafe && (st_r == dsf_pkg::DSF_RUN
                   || st_r == dsf_pkg::DSF_SEEK)) begin
        // bad supply drops settled, seek abandoned
        st_r <= dsf_pkg::DSF_RDY;
      end else begin
        case (st_r)
          dsf_pkg::DSF_SPIN: begin
            if (spindle_ok) begin
              st_r <= dsf_pkg::DSF_RECAL;
            end
          end
          dsf_pkg::DSF_RECAL: begin
            if (cyl_r == '0) begin
              st_r <= dsf_pkg::DSF_INIT;
            end
          end
          dsf_pkg::DSF_INIT: begin
            if (ctrl_r[dsf_pkg::CTRL_INIT] && spindle_ok
                && !supply_unsafe) begin
              st_r <= dsf_pkg::DSF_RDY;
            end
          end
          dsf_pkg::DSF_RDY: begin
            // ready a cycle ahead of settled, also on recovery
            if (!supply_unsafe) begin
              st_r <= dsf_pkg::DSF_RUN;
            end
          end
          dsf_pkg::DSF_RUN: begin
            if (step_ok || retry_ev) begin
              st_r <= dsf_pkg::DSF_SEEK;
            end
          end
          dsf_pkg::DSF_SEEK: begin
            if (settle_done && !retry_ev) begin
              st_r <= dsf_pkg::DSF_RUN;
            end
          end
          default: st_r <= dsf_pkg::DSF_SPIN;
        endcase
      end
    end
  end

  // Settling timer, reloaded on step or retry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_r <= 32'h0;
    end else if (ce) begin
      if (step_ok || retry_ev) begin
        settle_r <= SETTLE_CYC;
      end else if (settle_r != 32'h0) begin
        settle_r <= settle_r - 32'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      retry_r <= 2'h0;
    end else if (ce) begin
      if (step_ok) begin
        retry_r <= 2'h0;
      end else if (retry_ev && retry_r != 2'h3) begin
        retry_r <= retry_r + 2'h1;
      end
    end
  end

  // head position, recal walks to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyl_r <= CW'(dsf_pkg::CYL_PARK);
      div_r <= 8'h0;
    end else if (ce) begin
      if (st_r == dsf_pkg::DSF_RECAL && cyl_r != '0) begin
        if (div_r == 8'(RECAL_DIV - 1)) begin
          div_r <= 8'h0;
          cyl_r <= cyl_r - CW'(1);
        end else begin
          div_r <= div_r + 8'h1;
        end
      end else if (step_ok) begin
        if (!dir_in_n && cyl_r < CW'(dsf_pkg::CYL_MAX)) begin
          cyl_r <= cyl_r + CW'(1);
        end else if (dir_in_n && cyl_r != '0) begin
          cyl_r <= cyl_r - CW'(1);
        end
      end
    end
  end

  // Heads out of parking once first recal lands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unparked_r <= 1'b0;
    end else if (ce && st_r == dsf_pkg::DSF_RECAL && cyl_r == '0) begin
      unparked_r <= 1'b1;
    end
  end
  assign rev_link.enable = unparked_r;

  // ready deadline watch, counting only until heads unpark, flagged in status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_cnt_r <= 32'h0;
      late_r    <= 1'b0;
    end else if (ce && !ready_w && !late_r && !unparked_r) begin
      if (rdy_cnt_r == READY_CYC - 1) begin
        late_r <= 1'b1;
      end else begin
        rdy_cnt_r <= rdy_cnt_r + 32'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hazard_r <= 1'b0;
    end else if (ce && sel) begin
      // Judged against commanded current, so its own lag is no fault
      if ((wcur_r && !wcur_sense)
          || (wcur_sense && !wg && !wcur_r)
          || (retry_ev && retry_r != 2'h0)
          || (supply_unsafe && ctrl_r[dsf_pkg::CTRL_DCU])) begin
        hazard_r <= 1'b1;
      end
    end
  end

  assign cur_ok = wg && head_r && ready_w && settled_w && !head_sel_fault
               && !supply_unsafe && !step_edge && !off_track && !hazard_r;

  // head first, then current, then data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      head_r   <= 1'b0;
      wcur_r   <= 1'b0;
      flux_r   <= 1'b0;
      pair_d_r <= 1'b0;
      step_d_r <= 1'b1;
    end else if (ce) begin
      head_r   <= wg;
      wcur_r   <= cur_ok;
      flux_r   <= wcur_r && pair_w && !pair_d_r;
      pair_d_r <= pair_w;
      step_d_r <= step_n;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_r <= 2'h0;
    end else if (ce) begin
      if (cyl_r >= CW'(dsf_pkg::CYL_RWC3)) begin
        lvl_r <= 2'h3;
      end else if (cyl_r >= CW'(dsf_pkg::CYL_RWC2)) begin
        lvl_r <= 2'h2;
      end else if (cyl_r >= CW'(dsf_pkg::CYL_RWC1)) begin
        lvl_r <= 2'h1;
      end else begin
        lvl_r <= 2'h0;
      end
    end
  end

  assign head_energize    = head_r;
  assign write_current_en = wcur_r;
  assign write_flux       = flux_r;
  assign wr_cur_level     = lvl_r;

  assign unit_selected_n = !sel;
  assign rev_marker_n    = !sel || rev_link.marker_n;
  assign home_cyl_n      = !(sel && cyl_r == '0);
  assign ready_n         = !(sel && ready_w);
  assign seek_settled_n  = !(sel && settled_w);
  assign write_hazard_n  = !(sel && hazard_r);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_sel;
    !unit_selected_n |-> ctrl_r[dsf_pkg::CTRL_VALID];
  endproperty
  a_sel: assert property (p_sel)
    else $error("selected without valid config");

  property p_home;
    !home_cyl_n |-> cyl_r == '0;
  endproperty
  a_home: assert property (p_home)
    else $error("home flag off cylinder zero");

  property p_step_ready;
    ce && step_edge && !settled_w && st_r != dsf_pkg::DSF_RECAL
      |=> cyl_r == $past(cyl_r);
  endproperty
  a_step_ready: assert property (p_step_ready)
    else $error("step moved heads while not ready");

  property p_ready_cond;
    ready_w |-> ctrl_r[dsf_pkg::CTRL_INIT] && !supply_unsafe
                && st_r != dsf_pkg::DSF_RECAL;
  endproperty
  a_ready_cond: assert property (p_ready_cond)
    else $error("ready before sequence done");

  property p_step_clear;
    ce && step_ok |=> !settled_w;
  endproperty
  a_step_clear: assert property (p_step_clear)
    else $error("settled stayed after step");

  property p_hazard_hold;
    hazard_r |=> hazard_r;
  endproperty
  a_hazard_hold: assert property (p_hazard_hold)
    else $error("hazard cleared without reset");

  property p_retry_haz;
    ce && sel && retry_ev && retry_r != 2'h0 |=> hazard_r;
  endproperty
  a_retry_haz: assert property (p_retry_haz)
    else $error("second retry missed hazard");

  property p_cur_cut;
    ce && write_current_en |-> $past(ready_w && !head_sel_fault);
  endproperty
  a_cur_cut: assert property (p_cur_cut)
    else $error("write current without safe state");

  property p_flux_order;
    write_flux |-> $past(head_r, 2);
  endproperty
  a_flux_order: assert property (p_flux_order)
    else $error("data passed before head energized");

  property p_level;
    ce && cyl_r >= CW'(dsf_pkg::CYL_RWC3) |=> wr_cur_level == 2'h3;
  endproperty
  a_level: assert property (p_level)
    else $error("write current level wrong");

  property p_gate;
    !sel |-> ready_n && seek_settled_n && write_hazard_n && rev_marker_n;
  endproperty
  a_gate: assert property (p_gate)
    else $error("status driven while deselected");

  property p_inward;
    ce && step_ok && !dir_in_n && cyl_r < CW'(dsf_pkg::CYL_MAX)
      |=> cyl_r == $past(cyl_r) + CW'(1);
  endproperty
  a_inward: assert property (p_inward)
    else $error("inward step did not advance");

  property p_ready_first;
    $rose(settled_w) |-> $past(ready_w);
  endproperty
  a_ready_first: assert property (p_ready_first)
    else $error("settled before ready");
endmodule : dsf_status

// >>> tb/dsf_host_model.sv
// Purpose: host controller model driving select, step and write lines
// Assumes: single pclk, changes right after a rising edge
// Notes:   waits on drive status before any move or write
`timescale 1ns/1ps
module dsf_host_model (
  // Clock
  input  wire logic       pclk,
  // Drive status
  input  wire logic       ready_n,
  input  wire logic       seek_settled_n,
  input  wire logic       write_hazard_n,
  input  wire logic       unit_selected_n,
  // Host lines
  output logic [3:0]      unit_sel_n,
  output logic            write_gate_n,
  output logic            step_n,
  output logic            dir_in_n,
  output logic            wd_pos,
  output logic            wd_neg
);
  initial begin
    unit_sel_n   = 4'hF;
    write_gate_n = 1'h1;
    step_n       = 1'h1;
    dir_in_n     = 1'h1;
    wd_pos       = 1'h0;
    wd_neg       = 1'h1;
  end

  // Unit 4 drops every select line
  task automatic sel(input logic [2:0] u);
    @(posedge pclk);
    unit_sel_n <= ~4'((5'h01 << u));
  endtask : sel

  task automatic step(input logic inward);
    wait (ready_n === 1'h0 && seek_settled_n === 1'h0);
    @(posedge pclk);
    dir_in_n <= ~inward;
    @(posedge pclk);
    step_n <= 1'h0;
    repeat (2) @(posedge pclk);
    step_n <= 1'h1;
  endtask : step

  task automatic write(input int n);
    wait (write_hazard_n === 1'h1 && ready_n === 1'h0 &&
          seek_settled_n === 1'h0 && unit_selected_n === 1'h0);
    @(posedge pclk);
    write_gate_n <= 1'h0;
    repeat (3) @(posedge pclk);
    // pos over neg marks flux; idle pair inactive
    repeat (n) begin
      wd_pos <= 1'h1;
      wd_neg <= 1'h0;
      repeat (2) @(posedge pclk);
      wd_pos <= 1'h0;
      wd_neg <= 1'h1;
      repeat (2) @(posedge pclk);
    end
    write_gate_n <= 1'h1;
  endtask : write
endmodule : dsf_host_model

// >>> tb/tb_dsf_status.sv
// Purpose: self-checking bench for the disk status and fault logic
// Assumes: short revolution, deadline and settle counts
// Notes:   write sense follows the current enable, fault forced on demand
`timescale 1ns/1ps
module tb_dsf_status;
  localparam int unsigned RC = 200;
  localparam int unsigned RW = 4;
  logic        pclk = 1'h0, presetn = 1'h0, ce = 1'h1;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        err;
  logic [3:0]  unit_sel_n;
  logic        write_gate_n, step_n, dir_in_n, wd_pos, wd_neg, wcur_sense;
  logic        spindle_ok = 1'h0, supply_unsafe = 1'h0, off_track = 1'h0;
  logic        head_sel_fault = 1'h0, fake = 1'h0;
  logic        unit_selected_n, rev_marker_n, home_cyl_n, ready_n;
  logic        seek_settled_n, write_hazard_n, head_energize;
  logic        write_current_en, write_flux;
  logic [1:0]  wr_cur_level;
  int          bad_count = 0, n_tests = 0, cyc = 0, flux_cnt = 0, u, n;
  time         t0;

  // Sensed current mirrors the commanded current, or is forced
  assign wcur_sense = write_current_en | fake;
  always #50 pclk = ~pclk;

  dsf_status #(.REV_CYC(RC), .REV_WIDTH(RW), .READY_CYC(8000),
    .SETTLE_CYC(8), .RECAL_DIV(8)) i_dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .unit_sel_n(unit_sel_n), .write_gate_n(write_gate_n), .step_n(step_n),
    .dir_in_n(dir_in_n), .encoded_write_pair_pos(wd_pos),
    .encoded_write_pair_neg(wd_neg), .spindle_ok(spindle_ok),
    .supply_unsafe(supply_unsafe), .head_sel_fault(head_sel_fault),
    .off_track(off_track), .wcur_sense(wcur_sense),
    .unit_selected_n(unit_selected_n), .rev_marker_n(rev_marker_n),
    .home_cyl_n(home_cyl_n), .ready_n(ready_n),
    .seek_settled_n(seek_settled_n), .write_hazard_n(write_hazard_n),
    .head_energize(head_energize), .write_current_en(write_current_en),
    .write_flux(write_flux), .wr_cur_level(wr_cur_level));

  dsf_host_model i_host (
    .pclk(pclk), .ready_n(ready_n), .seek_settled_n(seek_settled_n),
    .write_hazard_n(write_hazard_n), .unit_selected_n(unit_selected_n),
    .unit_sel_n(unit_sel_n), .write_gate_n(write_gate_n), .step_n(step_n),
    .dir_in_n(dir_in_n), .wd_pos(wd_pos), .wd_neg(wd_neg));

  task automatic stop_test();
    if (bad_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  function automatic logic [1:0] lvl(input int c);
    return (c >= dsf_pkg::CYL_RWC3) ? 2'h3 : (c >= dsf_pkg::CYL_RWC2) ?
           2'h2 : (c >= dsf_pkg::CYL_RWC1) ? 2'h1 : 2'h0;
  endfunction : lvl

  // Hang guard, well above the longest expected run
  always @(posedge pclk) begin
    cyc++;
    if (write_flux === 1'h1) flux_cnt++;
    if (cyc == 80000) begin
      bad_count++;
      stop_test();
    end
  end

  initial begin
    void'($urandom(97));
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    u = $urandom_range(3, 0);
    @(posedge pclk);
    #1 chk(32'(rev_marker_n & ready_n & home_cyl_n), 32'h1, "idle");
    apb(1'h1, dsf_pkg::ADDR_CTRL, 32'(32'h24 | u));
    i_host.sel(3'((u + 1) % 4));
    repeat (2) @(posedge pclk);
    #1 chk(32'(unit_selected_n), 32'h1, "other unit");
    i_host.sel(3'(u));
    repeat (2) @(posedge pclk);
    #1 chk(32'(unit_selected_n), 32'h0, "own unit");
    apb(1'h0, dsf_pkg::ADDR_CTRL, 32'h0);
    chk(q, 32'(32'h24 | u), "ctrl readback");
    chk(32'(err), 32'h0, "mapped no error");
    apb(1'h0, 8'h08, 32'h0);
    chk(q, 32'h0, "unmapped read");
    chk(32'(err), 32'h1, "unmapped error");
    n = 0;
    repeat (RC + 10) @(posedge pclk) if (rev_marker_n !== 1'h1) n = 1;
    chk(32'(n), 32'h0, "marker while parked");
    spindle_ok <= 1'h1;
    wait (ready_n === 1'h0);
    #1 chk(32'(seek_settled_n), 32'h1, "ready first");
    chk(32'(home_cyl_n), 32'h0, "home at power-on");
    wait (seek_settled_n === 1'h0);
    apb(1'h0, dsf_pkg::ADDR_STAT, 32'h0);
    chk(q & 32'h10FFF, 32'hC00, "stat after power-on");
    @(negedge rev_marker_n) t0 = $time;
    @(posedge rev_marker_n);
    chk(32'(($time - t0) / 100), RW, "width");
    @(negedge rev_marker_n);
    chk(32'(($time - t0) / 100), RC, "period");
    for (int c = 1; c <= 550; c++) begin
      i_host.step(1'h1);
      #1 chk(32'(seek_settled_n), 32'h1, "settle drop");
      chk(32'(home_cyl_n), 32'h1, "home off");
      wait (seek_settled_n === 1'h0);
      #1 chk(32'(wr_cur_level), 32'(lvl(c)), "current level");
    end
    n = $urandom_range(6, 1);
    repeat (n) i_host.step(1'h0);
    wait (seek_settled_n === 1'h0);
    // Clock enable dropped in the access phase stalls the read
    fork
      apb(1'h0, dsf_pkg::ADDR_STAT, 32'h0);
      begin
        repeat (2) @(posedge pclk);
        ce <= 1'h0;
        @(posedge pclk);
        #1 chk(32'(pready), 32'h0, "ce stall");
        repeat (3) @(posedge pclk);
        ce <= 1'h1;
      end
    join
    chk(q & 32'h3FF, 32'(550 - n), "cylinder");
    n = $urandom_range(8, 3);
    flux_cnt = 0;
    fork
      i_host.write(n);
      begin
        wait (head_energize === 1'h1);
        #1 chk(32'(write_current_en), 32'h0, "head first");
        @(posedge pclk);
        #1 chk(32'(write_current_en), 32'h1, "current on");
      end
    join
    repeat (3) @(posedge pclk);
    chk(32'(flux_cnt), 32'(n), "flux count");
    fork
      i_host.write(8);
      begin
        wait (write_current_en === 1'h1);
        @(posedge pclk) off_track <= 1'h1;
        @(posedge pclk) off_track <= 1'h0;
        repeat (2) @(posedge pclk);
        #1 chk(32'(write_current_en), 32'h0, "off-track cut");
        wait (write_current_en === 1'h1);
        @(posedge pclk) head_sel_fault <= 1'h1;
        @(posedge pclk) head_sel_fault <= 1'h0;
        #1 chk(32'(write_current_en), 32'h0, "head fault cut");
      end
    join
    wait (seek_settled_n === 1'h0);
    @(posedge pclk) supply_unsafe <= 1'h1;
    repeat (2) @(posedge pclk);
    #1 chk(32'({ready_n, seek_settled_n}), 32'h3, "supply unsafe");
    @(posedge pclk) supply_unsafe <= 1'h0;
    apb(1'h1, dsf_pkg::ADDR_CTRL, 32'(32'h64 | u));
    wait (home_cyl_n === 1'h0);
    wait (seek_settled_n === 1'h0);
    #1 chk(32'(write_hazard_n), 32'h1, "no hazard yet");
    @(posedge pclk) fake <= 1'h1;
    repeat (3) @(posedge pclk);
    fake <= 1'h0;
    repeat (10) @(posedge pclk);
    #1 chk(32'(write_hazard_n), 32'h0, "hazard sticky");
    i_host.sel(3'h4);
    repeat (2) @(posedge pclk);
    #1 chk(32'(write_hazard_n & ready_n), 32'h1, "gated off");
    i_host.sel(3'(u));
    @(posedge pclk) presetn <= 1'h0;
    @(posedge pclk) presetn <= 1'h1;
    repeat (2) @(posedge pclk);
    #1 chk(32'(unit_selected_n), 32'h1, "invalid config");
    apb(1'h0, dsf_pkg::ADDR_STAT, 32'h0);
    chk(q & 32'h1000, 32'h0, "hazard cleared");
    // Radial config selects with every line idle
    i_host.sel(3'h4);
    apb(1'h1, dsf_pkg::ADDR_CTRL, 32'h0000002C);
    #1 chk(32'(unit_selected_n), 32'h0, "radial");
    wait (seek_settled_n === 1'h0);
    @(posedge pclk) off_track <= 1'h1;
    repeat (5) @(posedge pclk);
    #1 chk(32'(write_hazard_n), 32'h1, "one retry");
    repeat (7) @(posedge pclk);
    off_track <= 1'h0;
    #1 chk(32'(write_hazard_n), 32'h0, "second retry");
    stop_test();
  end
endmodule : tb_dsf_status
